// [rtl/cftg_defines.svh]
`ifndef CFTG_DEFINES_SVH
`define CFTG_DEFINES_SVH

// ****************************************
// Register offsets
// ****************************************
`define CFTG_OFS_TRIG_CTL 8'h18
`define CFTG_OFS_HIGH_UPPER 8'h19
`define CFTG_OFS_HIGH_LOWER 8'h1A
`define CFTG_OFS_LOW_UPPER 8'h1B
`define CFTG_OFS_LOW_LOWER 8'h1C
`define CFTG_OFS_RATE_SEL 8'h58

// ****************************************
// Reset values
// ****************************************
`define CFTG_RST_BYTE 8'h00
`define CFTG_RST_RATE 3'h0

// ****************************************
// Field positions and codes
// ****************************************
`define CFTG_CTL_ENABLE_BIT 0
`define CFTG_CTL_SHAPE_BIT 1
`define CFTG_CTL_INIT_BIT 2
`define CFTG_CTL_SRC_LSB 4
`define CFTG_CTL_SRC_MSB 7
`define CFTG_RATE_LSB 0
`define CFTG_RATE_MSB 2
`define CFTG_CTL_WRITE_MASK 8'hF7
`define CFTG_SRC_LINK0 4'h0
`define CFTG_SRC_GPIO_FIRST 4'h8
`define CFTG_SRC_GPIO_LAST 4'hE
`define CFTG_RATE_50M 3'h6

// ****************************************
// Timing
// ****************************************
`define CFTG_CLK_PERIOD_NS 10
`define CFTG_FRAME_BITS 30
`define CFTG_BIT_NS_50M 20
`define CFTG_BIT_NS_2M5 400

`endif

// [rtl/cftg_pkg.sv]
`default_nettype none

package cftg_pkg;

  typedef enum logic [1:0] {
    CFTG_MODE_OFF = 2'b00,
    CFTG_MODE_EXTERNAL = 2'b01,
    CFTG_MODE_INTERNAL = 2'b10
  } cftg_mode_e;

  typedef struct packed {
    logic [3:0] trigger_source_select;
    logic reserved;
    logic initial_level;
    logic waveform_shape_select;
    logic generator_enable;
  } cftg_ctl_s;

  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cftg_reg_req_s;

  typedef struct packed {
    logic trigger_link0;
    logic trigger_link1;
  } cftg_link_out_s;

endpackage : cftg_pkg

`default_nettype wire

// [rtl/cftg_sync2.sv]
`include "cftg_defines.svh"
`default_nettype none

module cftg_sync2 #(
  parameter int WIDTH = 7
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb begin
    meta_d = clk_en ? async_in : meta_q;
    sync_d = clk_en ? meta_q : sync_q;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule // cftg_sync2

`default_nettype wire

// [rtl/cftg_tick_gen.sv]
`include "cftg_defines.svh"
`default_nettype none

// One pulse per back-channel frame of thirty bit times
module cftg_tick_gen #(
  parameter int CNT_W = 12
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic [2:0] rate_sel,
  output logic tick
);

  localparam int BIT_CYC_50M = (`CFTG_BIT_NS_50M + `CFTG_CLK_PERIOD_NS - 1) / `CFTG_CLK_PERIOD_NS;
  localparam int BIT_CYC_2M5 = (`CFTG_BIT_NS_2M5 + `CFTG_CLK_PERIOD_NS - 1) / `CFTG_CLK_PERIOD_NS;
  localparam logic [CNT_W-1:0] LAST_50M = CNT_W'(`CFTG_FRAME_BITS * BIT_CYC_50M - 1);
  localparam logic [CNT_W-1:0] LAST_2M5 = CNT_W'(`CFTG_FRAME_BITS * BIT_CYC_2M5 - 1);

  // Last cycle count of one frame for a rate code
  function automatic logic [CNT_W-1:0] frame_last(input logic [2:0] sel);
    frame_last = (sel == `CFTG_RATE_50M) ? LAST_50M : LAST_2M5; // [RL6] [RL13]
  endfunction

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic tick_q;
  logic tick_d;

  always_comb begin
    cnt_d = cnt_q;
    tick_d = tick_q;
    if (clk_en) begin
      tick_d = 1'b0;
      // Compare with >= so a rate change mid-frame cannot run past the end
      if (cnt_q >= frame_last(rate_sel)) begin
        cnt_d = '0;
        tick_d = 1'b1;
      end else begin
        cnt_d = cnt_q + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;

endmodule // cftg_tick_gen

`default_nettype wire

// [rtl/cftg_trigger_gen.sv]
// Notes on behaviour
// RL1: Source 0x8..0xE with generator off relays local pin 0..6 as the trigger.
// RL2: Relayed trigger is resampled each back-channel frame, about 600 ns skew.
// RL3: Software maps a back-channel GPIO slot to the trigger in the link logic.
// RL4: Writing 1 to generator enable selects internal counter mode.
// RL5: Once enabled, pulses repeat continuously without software action.
// RL6: Generator tick is one back-channel frame of thirty bit times.
// RL7: In internal mode source select 0x0 picks link 0 frame period.
// RL8: Control bit 1 picks separate high/low periods or 50/50 duty.
// RL9: Control bit 2 sets the starting level when generation begins.
// RL10: High and low counts are 16 bits, upper byte at the lower offset.
// RL11: Trigger stays high then low for the programmed tick counts.
// RL12: Software scales counts when the reference clock is not 25 MHz.
// RL13: Link 0 rate field at 0x58 bits 2:0 sets the tick; 110b is 50 Mbps.
// RL14: Both back-channel links carry the same trigger edge together.
// RL15: A count of N lasts N plus one ticks.
// RL16: While disabled, counter is cleared and output held at initial level; with source 0x8..0xE the output relays the pin instead.
`include "cftg_defines.svh"
`default_nettype none

module cftg_trigger_gen #(
  parameter int GPIO_W = 7,
  parameter int COUNT_W = 16
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic clk_en,
  input wire cftg_pkg::cftg_reg_req_s reg_req,
  output logic [7:0] reg_rdata,
  input wire logic [GPIO_W-1:0] gpio_in,
  output cftg_pkg::cftg_link_out_s link_out,
  output logic frame_tick
);

  // ****************************************
  // Register file
  // ****************************************
  cftg_pkg::cftg_ctl_s ctl_q;
  cftg_pkg::cftg_ctl_s ctl_d;
  logic [7:0] high_upper_q;
  logic [7:0] high_upper_d;
  logic [7:0] high_lower_q;
  logic [7:0] high_lower_d;
  logic [7:0] low_upper_q;
  logic [7:0] low_upper_d;
  logic [7:0] low_lower_q;
  logic [7:0] low_lower_d;
  logic [2:0] rate_q;
  logic [2:0] rate_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  // Write strobe decode for one offset
  function automatic logic wr_hit(input cftg_pkg::cftg_reg_req_s req, input logic [7:0] ofs);
    wr_hit = req.wr_en && (req.addr == ofs);
  endfunction

  // Control byte; the reserved bit is dropped so it always reads back zero
  always_comb begin
    ctl_d = ctl_q;
    if (clk_en && wr_hit(reg_req, `CFTG_OFS_TRIG_CTL)) begin
      ctl_d = cftg_pkg::cftg_ctl_s'(reg_req.wdata & `CFTG_CTL_WRITE_MASK); // [RL4]
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctl_q <= cftg_pkg::cftg_ctl_s'(`CFTG_RST_BYTE);
    end else begin
      ctl_q <= ctl_d;
    end
  end

  // Count bytes are live, so a half-written count takes effect at once
  always_comb begin
    high_upper_d = high_upper_q;
    high_lower_d = high_lower_q;
    low_upper_d = low_upper_q;
    low_lower_d = low_lower_q;
    if (clk_en) begin
      if (wr_hit(reg_req, `CFTG_OFS_HIGH_UPPER)) begin
        high_upper_d = reg_req.wdata; // [RL10]
      end
      if (wr_hit(reg_req, `CFTG_OFS_HIGH_LOWER)) begin
        high_lower_d = reg_req.wdata; // [RL10]
      end
      if (wr_hit(reg_req, `CFTG_OFS_LOW_UPPER)) begin
        low_upper_d = reg_req.wdata; // [RL10]
      end
      if (wr_hit(reg_req, `CFTG_OFS_LOW_LOWER)) begin
        low_lower_d = reg_req.wdata; // [RL10]
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      high_upper_q <= `CFTG_RST_BYTE;
      high_lower_q <= `CFTG_RST_BYTE;
      low_upper_q <= `CFTG_RST_BYTE;
      low_lower_q <= `CFTG_RST_BYTE;
    end else begin
      high_upper_q <= high_upper_d;
      high_lower_q <= high_lower_d;
      low_upper_q <= low_upper_d;
      low_lower_q <= low_lower_d;
    end
  end

  // Any code but the fast one falls back to the slow frame
  always_comb begin
    rate_d = rate_q;
    if (clk_en && wr_hit(reg_req, `CFTG_OFS_RATE_SEL)) begin
      rate_d = reg_req.wdata[`CFTG_RATE_MSB:`CFTG_RATE_LSB]; // [RL13]
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rate_q <= `CFTG_RST_RATE;
    end else begin
      rate_q <= rate_d;
    end
  end

  // Unmapped offsets read zero; a read beside a write returns the old value
  always_comb begin
    rdata_d = rdata_q;
    if (clk_en && reg_req.rd_en) begin
      case (reg_req.addr)
        `CFTG_OFS_TRIG_CTL: rdata_d = ctl_q;
        `CFTG_OFS_HIGH_UPPER: rdata_d = high_upper_q;
        `CFTG_OFS_HIGH_LOWER: rdata_d = high_lower_q;
        `CFTG_OFS_LOW_UPPER: rdata_d = low_upper_q;
        `CFTG_OFS_LOW_LOWER: rdata_d = low_lower_q;
        `CFTG_OFS_RATE_SEL: rdata_d = {5'h00, rate_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= `CFTG_RST_BYTE;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // ****************************************
  // Pin synchroniser and frame tick
  // ****************************************
  logic [GPIO_W-1:0] gpio_sync;
  logic tick;

  cftg_sync2 #(
    .WIDTH(GPIO_W)
  ) u_sync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .clk_en(clk_en),
    .async_in(gpio_in),
    .sync_out(gpio_sync)
  );

  // Only link 0 rate is held here, so every internal source uses its frame
  cftg_tick_gen u_tick (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .clk_en(clk_en),
    .rate_sel(rate_q),
    .tick(tick)
  ); // [RL7] [RL6]

  assign frame_tick = tick;

  // ****************************************
  // Mode decode
  // ****************************************
  cftg_pkg::cftg_mode_e mode;
  logic [3:0] src;
  logic [3:0] pin_idx;
  logic [COUNT_W-1:0] high_count;
  logic [COUNT_W-1:0] low_count;

  assign src = ctl_q.trigger_source_select;
  assign pin_idx = src - `CFTG_SRC_GPIO_FIRST;
  assign high_count = COUNT_W'({high_upper_q, high_lower_q}); // [RL10]
  assign low_count = COUNT_W'({low_upper_q, low_lower_q}); // [RL10]

  always_comb begin
    if (ctl_q.generator_enable) begin
      mode = cftg_pkg::CFTG_MODE_INTERNAL; // [RL4]
    end else if (src >= `CFTG_SRC_GPIO_FIRST && src <= `CFTG_SRC_GPIO_LAST) begin
      mode = cftg_pkg::CFTG_MODE_EXTERNAL; // [RL1]
    end else begin
      mode = cftg_pkg::CFTG_MODE_OFF;
    end
  end

  // Last count of the phase that the given level occupies
  function automatic logic [COUNT_W-1:0] phase_last(input logic lvl, input logic half,
                                                     input logic [COUNT_W-1:0] hi,
                                                     input logic [COUNT_W-1:0] lo);
    if (half) begin
      phase_last = hi; // [RL8]
    end else begin
      phase_last = lvl ? hi : lo; // [RL8] [RL11]
    end
  endfunction

  // ****************************************
  // Generator
  // ****************************************
  logic [COUNT_W-1:0] cnt_q;
  logic [COUNT_W-1:0] cnt_d;
  logic level_q;
  logic level_d;
  logic trig_q;
  logic trig_d;

  // Counter and level; both restart whenever the generator is off
  always_comb begin
    cnt_d = cnt_q;
    level_d = level_q;
    if (clk_en) begin
      case (mode)
        cftg_pkg::CFTG_MODE_INTERNAL: begin
          if (tick) begin
            // Count runs 0..N so each phase spans N+1 ticks
            if (cnt_q >= phase_last(level_q, ctl_q.waveform_shape_select, high_count, low_count)) begin
              cnt_d = '0; // [RL15]
              level_d = !level_q; // [RL5] [RL11]
            end else begin
              cnt_d = cnt_q + COUNT_W'(1);
            end
          end
        end
        cftg_pkg::CFTG_MODE_EXTERNAL: begin
          cnt_d = '0;
          level_d = ctl_d.initial_level;
        end
        cftg_pkg::CFTG_MODE_OFF: begin
          // Preload from the incoming byte so an enabling write starts at its own level
          cnt_d = '0; // [RL16]
          level_d = ctl_d.initial_level; // [RL16] [RL9]
        end
        default: begin
          cnt_d = '0;
          level_d = ctl_d.initial_level;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
      level_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      level_q <= level_d;
    end
  end

  // Pin level trails the counter level by one cycle
  always_comb begin
    trig_d = trig_q;
    if (clk_en) begin
      case (mode)
        cftg_pkg::CFTG_MODE_INTERNAL: begin
          trig_d = level_q;
        end
        cftg_pkg::CFTG_MODE_EXTERNAL: begin
          // Resample once per frame, like the back-channel slot would
          if (tick) begin
            trig_d = gpio_sync[pin_idx[2:0]]; // [RL1] [RL2]
          end
        end
        cftg_pkg::CFTG_MODE_OFF: begin
          trig_d = ctl_q.initial_level; // [RL16]
        end
        default: begin
          trig_d = ctl_q.initial_level;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      trig_q <= 1'b0;
    end else begin
      trig_q <= trig_d;
    end
  end

  // One flop feeds both links so their edges never part
  assign link_out.trigger_link0 = trig_q; // [RL14]
  assign link_out.trigger_link1 = trig_q; // [RL14]

endmodule // cftg_trigger_gen

`default_nettype wire

// [verification/cftg_props.sv]
`default_nettype none

module cftg_props #(
  parameter int GPIO_W = 7
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic clk_en,
  input wire cftg_pkg::cftg_reg_req_s reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic [GPIO_W-1:0] gpio_in,
  input wire cftg_pkg::cftg_link_out_s link_out,
  input wire logic frame_tick
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Shadow of programmed state
  // ****************************************
  logic [4:0][7:0] sh_q, sh_d;
  logic [2:0] rate_q, rate_d;
  logic [15:0] cfg_q, cfg_d, gst_q, gst_d, thr;
  logic [10:0] gap_q, gap_d;
  logic [16:0] tk_q, tk_d;
  logic ph_q, ph_d, trg_q;
  logic [GPIO_W-1:0] gp_q;
  cftg_pkg::cftg_ctl_s ctl;
  logic trig, wr, gsel, edg;
  assign ctl = cftg_pkg::cftg_ctl_s'(sh_q[0]);
  assign trig = link_out.trigger_link0;
  assign wr = clk_en && reg_req.wr_en;
  assign edg = trig != trg_q;
  assign gsel = ctl.trigger_source_select[3] && ctl.trigger_source_select[2:0] != 3'h7;
  // Settling allowance follows the frame rate in use
  assign thr = (rate_q == 3'h6) ? 16'h0046 : 16'h04BA;

  always_comb begin
    sh_d = sh_q;
    rate_d = rate_q;
    cfg_d = (cfg_q == 16'hFFFF) ? cfg_q : cfg_q + 16'h0001;
    gst_d = (gp_q != gpio_in) ? 16'h0000 : (gst_q == 16'hFFFF) ? gst_q : gst_q + 16'h0001;
    gap_d = frame_tick ? 11'h000 : gap_q + 11'h001;
    tk_d = edg ? 17'(frame_tick) : tk_q + 17'(frame_tick);
    ph_d = ph_q || edg;
    if (wr) begin
      cfg_d = 16'h0000;
      ph_d = 1'b0;
      if (reg_req.addr inside {[8'h18:8'h1C]}) begin
        sh_d[reg_req.addr[2:0]] = reg_req.wdata & ((reg_req.addr == 8'h18) ? 8'hF7 : 8'hFF);
      end
      if (reg_req.addr == 8'h58) begin
        rate_d = reg_req.wdata[2:0];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sh_q <= '0;
      rate_q <= 3'h0;
      cfg_q <= 16'h0000;
      gst_q <= 16'h0000;
      gap_q <= 11'h000;
      tk_q <= 17'h00000;
      ph_q <= 1'b0;
      trg_q <= 1'b0;
      gp_q <= '0;
    end else if (clk_en) begin
      sh_q <= sh_d;
      rate_q <= rate_d;
      cfg_q <= cfg_d;
      gst_q <= gst_d;
      gap_q <= gap_d;
      tk_q <= tk_d;
      ph_q <= ph_d;
      trg_q <= trig;
      gp_q <= gpio_in;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_tick_single: assert property (frame_tick && clk_en ##1 clk_en |-> !frame_tick)
    else $error("frame tick wider than one cycle");
  a_tick_gap: assert property (frame_tick && clk_en && cfg_q > 16'h04BA |-> gap_q == ((rate_q == 3'h6) ? 11'h03B : 11'h4AF))
    else $error("frame tick spacing wrong");
  a_links_same: assert property (link_out.trigger_link0 == link_out.trigger_link1)
    else $error("link triggers differ");
  a_read_back: assert property (clk_en && reg_req.rd_en && reg_req.addr inside {[8'h18:8'h1C]} |=> reg_rdata == $past(sh_q[reg_req.addr[2:0]]))
    else $error("register read data wrong");
  a_off_level: assert property (!ctl.generator_enable && !gsel && cfg_q > 16'h0004 |-> trig == ctl.initial_level)
    else $error("disabled trigger not at initial level");
  a_ext_relay: assert property (!ctl.generator_enable && gsel && cfg_q > thr && gst_q > thr |-> trig == gpio_in[ctl.trigger_source_select[2:0]])
    else $error("relayed pin level wrong");
  a_int_start: assert property (wr && reg_req.addr == 8'h18 && reg_req.wdata[0] && !ctl.generator_enable && sh_q[2] != 8'h00 && sh_q[4] != 8'h00 |-> ##4 trig == $past(reg_req.wdata[2], 4))
    else $error("generation did not start at initial level");
  a_edge_tick: assert property (ctl.generator_enable && cfg_q > 16'h0004 && edg |-> $past(frame_tick) || $past(frame_tick, 2) || $past(frame_tick, 3) || $past(frame_tick, 4))
    else $error("trigger edge not after a tick");
  a_phase_len: assert property (ctl.generator_enable && ph_q && edg |-> tk_q == ((trg_q || ctl.waveform_shape_select) ? {1'b0, sh_q[1], sh_q[2]} : {1'b0, sh_q[3], sh_q[4]}) + 17'h00001)
    else $error("phase tick count wrong");
endmodule // cftg_props

bind cftg_trigger_gen cftg_props #(.GPIO_W(GPIO_W)) u_props (.clk_sys(clk_sys), .rstn(rstn), .clk_en(clk_en),
  .reg_req(reg_req), .reg_rdata(reg_rdata), .gpio_in(gpio_in), .link_out(link_out), .frame_tick(frame_tick));

`default_nettype wire

// [verification/cftg_ser_model.sv]
`default_nettype none

module cftg_ser_model (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic trig,
  output logic [31:0] hi_len,
  output logic [31:0] lo_len
);
  timeunit 1ns;
  timeprecision 1ns;
  logic prev_q;
  logic [31:0] run_q;
  // Slot that software mapped to the trigger, seen every cycle; finished phases only
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      prev_q <= 1'b0;
      run_q <= 0;
      hi_len <= 0;
      lo_len <= 0;
    end else if (trig != prev_q) begin
      prev_q <= trig;
      run_q <= 1;
      if (prev_q) hi_len <= run_q;
      else lo_len <= run_q;
    end else begin
      run_q <= run_q + 1;
    end
  end
endmodule // cftg_ser_model

`default_nettype wire

// [verification/tb.sv]
`include "cftg_defines.svh"
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TK = `CFTG_FRAME_BITS * `CFTG_BIT_NS_50M / `CFTG_CLK_PERIOD_NS;
  localparam int TS = `CFTG_FRAME_BITS * `CFTG_BIT_NS_2M5 / `CFTG_CLK_PERIOD_NS;
  logic clk_sys, rstn, clk_en, frame_tick;
  cftg_pkg::cftg_reg_req_s reg_req;
  cftg_pkg::cftg_link_out_s link_out;
  logic [7:0] reg_rdata;
  logic [6:0] gpio_in;
  logic [31:0] hi_len, lo_len;
  int n_errors = 0;
  int checks_done = 0;

  cftg_trigger_gen u_dut (.clk_sys(clk_sys), .rstn(rstn), .clk_en(clk_en), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .gpio_in(gpio_in), .link_out(link_out), .frame_tick(frame_tick));
  cftg_ser_model u_ser (.clk_sys(clk_sys), .rstn(rstn), .trig(link_out.trigger_link0),
    .hi_len(hi_len), .lo_len(lo_len));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_req <= '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    reg_req <= '0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_req <= '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys);
    reg_req <= '0;
    @(negedge clk_sys);
    chk($sformatf("reg %0h", a), e, reg_rdata);
  endtask

  // Cycles from one frame tick to the next
  task automatic tick_gap(output int n);
    n = 1;
    @(negedge clk_sys);
    for (int i = 0; i < 2500 && frame_tick !== 1'b1; i++) @(negedge clk_sys);
    @(negedge clk_sys);
    while (n < 2500 && frame_tick !== 1'b1) begin
      n++;
      @(negedge clk_sys);
    end
  endtask

  task automatic t_regs();
    for (int a = 8'h18; a <= 8'h1C; a++) rdchk(8'(a), 8'h00);
    wr(8'h19, 8'h0A);
    wr(8'h1A, 8'hD9);
    wr(8'h1B, 8'h61);
    wr(8'h1C, 8'hA7);
    wr(8'h18, 8'hF8);
    wr(8'h20, 8'h55);
    rdchk(8'h19, 8'h0A);
    rdchk(8'h1A, 8'hD9);
    rdchk(8'h1B, 8'h61);
    rdchk(8'h1C, 8'hA7);
    rdchk(8'h18, 8'hF0);
    rdchk(8'h20, 8'h00);
    @(posedge clk_sys);
    clk_en <= 1'b0;
    wr(8'h19, 8'h33);
    clk_en <= 1'b1;
    rdchk(8'h19, 8'h0A);
  endtask

  task automatic t_tick();
    int n;
    tick_gap(n);
    chk("slow tick gap", TS, n);
    wr(8'h58, 8'h06);
    rdchk(8'h58, 8'h06);
    tick_gap(n);
    tick_gap(n);
    chk("fast tick gap", TK, n);
  endtask

  task automatic t_int();
    wr(8'h19, 8'h00);
    wr(8'h1A, 8'h02);
    wr(8'h1B, 8'h00);
    wr(8'h1C, 8'h04);
    wr(8'h18, 8'h01);
    cyc(1500);
    chk("high len", 3 * TK, hi_len);
    chk("low len", 5 * TK, lo_len);
    wr(8'h18, 8'h03);
    cyc(1200);
    chk("even low len", 3 * TK, lo_len);
    chk("even high len", 3 * TK, hi_len);
    wr(8'h18, 8'h00);
    cyc(400);
    chk("held low", 0, link_out.trigger_link0);
    wr(8'h18, 8'h04);
    cyc(4);
    chk("held high", 1, link_out.trigger_link0);
    chk("link1 level", 1, link_out.trigger_link1);
    wr(8'h18, 8'h00);
    wr(8'h18, 8'h05);
    cyc(TK + 40);
    chk("start level", 1, link_out.trigger_link0);
    wr(8'h18, 8'h00);
  endtask

  task automatic t_ext();
    int n;
    for (int i = 0; i < 7; i++) begin
      wr(8'h18, 8'h80 + 8'(i * 16));
      @(posedge clk_sys);
      gpio_in <= 7'(1 << i);
      n = 0;
      while (n < 200 && link_out.trigger_link0 !== 1'b1) begin
        n++;
        @(negedge clk_sys);
      end
      chk("relay lag", 1, n <= TK + 4);
      @(posedge clk_sys);
      gpio_in <= ~7'(1 << i);
      cyc(2 * TK);
      chk("relay low", 0, link_out.trigger_link0);
    end
  endtask

  task automatic conclude();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    #500000;
    n_errors++;
    conclude();
  end

  initial begin
    rstn = 1'b0;
    clk_en = 1'b1;
    reg_req = '0;
    gpio_in = 7'h00;
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    t_regs();
    t_tick();
    t_int();
    t_ext();
    conclude();
  end
endmodule // tb

`default_nettype wire
